//--- ppa_pkg.sv
// package for the port pin configuration and port a data block
// assumes an 8-bit register port with one-cycle strobes and one clock
package ppa_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] PPA_OFS_DATA = 8'h00;  // port_a_data register
  localparam logic [7:0] PPA_OFS_DIR = 8'h01;  // port_a_direction
  localparam logic [7:0] PPA_OFS_WEAK = 8'h02;  // reduced_drive_bit per pin
  localparam logic [7:0] PPA_OFS_PULL_EN = 8'h03;  // pull_enable_bit per pin
  localparam logic [7:0] PPA_OFS_PULL_SEL = 8'h04;  // pull_select_bit per pin
  localparam logic [7:0] PPA_OFS_IRQ_EN = 8'h05;  // pin_irq_enable_bit per pin
  localparam logic [7:0] PPA_OFS_IF = 8'h06;  // edge flags, write one to clear
  localparam logic [7:0] PPA_OFS_LCD = 8'h07;  // lcd segment enable per pin
  localparam logic [7:0] PPA_OFS_ALT = 8'h08;  // alternate function enables

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int PPA_ALT_IRQ_BIT = 0;  // maskable interrupt input enable
  localparam int PPA_ALT_NMI_BIT = 1;  // nonmaskable interrupt input enable
  localparam int PPA_ALT_CLK_BIT = 3;  // autonomous clock output enable
  localparam int PPA_PIN_IRQ = 0;  // pin of the maskable input
  localparam int PPA_PIN_NMI = 1;  // pin of the nonmaskable input
  localparam int PPA_PIN_CLK = 3;  // pin of the clock output
  localparam logic [7:0] PPA_RST_VAL = 8'h00;  // every 8-bit register clears to zero
  localparam logic [7:0] PPA_ALL_ONES = 8'hff;  // fixed pull select of a, b
  localparam logic [7:0] PPA_READ_IDLE = 8'h00;  // unmapped read answer

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int PPA_SYNC_STAGES = 2;  // pin synchroniser depth, bus cycles

  // ****************************************************************
  // types
  // ****************************************************************
  // which family of port this instance stands for
  typedef enum logic [1:0] {
    PPA_PORT_AB,   // fixed pull select 1, no pin interrupts
    PPA_PORT_IRQ,  // free pull select, pin interrupts
    PPA_PORT_AD    // fixed pull select 0, pin interrupts
  } ppa_port_kind_t;

  // one register bus request
  typedef struct packed {
    logic [7:0] addr;   // register offset
    logic [7:0] wdata;  // write data
    logic wr;           // write strobe
    logic rd;           // read strobe
  } ppa_bus_req_t;

  // pad controls for the eight pins
  typedef struct packed {
    logic [7:0] out;        // level driven
    logic [7:0] oe;         // output enable
    logic [7:0] pull_up;    // pull-up device on
    logic [7:0] pull_down;  // pull-down device on
    logic [7:0] reduced;    // reduced drive strength
  } ppa_pad_ctl_t;

endpackage : ppa_pkg

//--- ppa_top.sv
// port pin configuration logic and the port a data register
// assumes pins and alternate-function inputs synchronous enough to sample with ref_clk
//
// Summary of operation
// RULE1 - direction 0 input, 1 drives output level
// RULE2 - input pull: select 0 up, 1 down
// RULE3 - no pull when disabled or output
// RULE4 - irq edge: select 0 falling, 1 rising
// RULE5 - reduced-drive bit selects weak output drive
// RULE6 - irq enable 0 blocks all edge flags
// RULE7 - pull select fixed 1 ports a,b; 0 ad
// RULE8 - pin interrupts only on irq-capable ports
// RULE9 - register reads fully synchronous to clock
// RULE10 - port a data at 0x0000, resets zero
// RULE11 - output mode drives data bit to pin
// RULE12 - read: register if output, else pin
// RULE13 - lcd segment overrides every pin function; code overrides pad drive and alternates only, edge flags still set on lcd pins
// RULE14 - bit 3 clock output beats gpio
// RULE15 - bit 1 nonmaskable input beats gpio
// RULE16 - bit 0 maskable input beats gpio
// RULE17 - data register accessible at any time
// RULE18 - alternates force the effective direction
// RULE19 - direction change visible within two cycles
// RULE20 - synchronised samples compared, flag per pin
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module ppa_top #(
  parameter ppa_pkg::ppa_port_kind_t PORT_KIND = ppa_pkg::PPA_PORT_AB  // port family
) (
  input wire logic ref_clk,                  // bus clock, 20 mhz
  input wire logic reset_n,                  // synchronous reset, active low
  input wire ppa_pkg::ppa_bus_req_t bus_req,  // register request
  output logic [7:0] rd_data,                // read data, cycle after strobe
  input wire logic [7:0] pin_in,             // pad input levels
  output ppa_pkg::ppa_pad_ctl_t pad_ctl,     // pad controls
  input wire logic [7:0] lcd_seg_drive,      // lcd segment driver levels
  input wire logic autonomous_clock_src,     // clock to put on pin 3
  output logic nonmaskable_int_input_n,      // pin 1 routed to nmi
  output logic maskable_int_input_n,         // pin 0 routed to irq
  output logic [7:0] pin_edge_flags          // sticky edge flags
);
  import ppa_pkg::*;

  // ****************************************************************
  // port family constants
  // ****************************************************************
  // fixed pull select, irq capability
  localparam logic PULL_SEL_FIXED = (PORT_KIND != PPA_PORT_IRQ);
  localparam logic [7:0] PULL_SEL_VALUE = (PORT_KIND == PPA_PORT_AB) ? PPA_ALL_ONES : PPA_RST_VAL;
  localparam logic IRQ_CAPABLE = (PORT_KIND != PPA_PORT_AB);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] port_a_data_q;      // stored output levels
  logic [7:0] port_a_direction_q; // software direction
  logic [7:0] reduced_drive_q;    // reduced drive bits
  logic [7:0] pull_enable_q;      // pull enable bits
  logic [7:0] pull_select_q;      // writable pull select
  logic [7:0] irq_enable_q;       // pin interrupt enables
  logic [7:0] edge_flags_q;       // sticky edge flags
  logic [7:0] lcd_seg_en_q;       // lcd segment enables
  logic [7:0] alt_en_q;           // alternate function enables
  logic [7:0] rd_data_q;          // read data register
  logic [7:0] sync1_q;            // first synchroniser stage
  logic [7:0] sync2_q;            // second synchroniser stage
  logic [7:0] prev_q;             // previous synchronised sample
  logic [7:0] pad_out_q;          // registered pad level
  logic [7:0] pad_oe_q;           // registered pad enable
  logic [7:0] pad_up_q;           // registered pull-up
  logic [7:0] pad_down_q;         // registered pull-down
  logic [7:0] pad_red_q;          // registered reduced drive
  logic nmi_n_q;                  // registered nmi route
  logic irq_n_q;                  // registered irq route

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // write strobe to a given offset
  function automatic logic wr_hit(input ppa_bus_req_t req, input logic [7:0] ofs);
    wr_hit = req.wr && (req.addr == ofs);
  endfunction : wr_hit

  // ****************************************************************
  // effective configuration
  // ****************************************************************
  logic [7:0] pull_select_eff;  // pull select after family forcing
  logic [7:0] irq_enable_eff;   // irq enable after capability
  logic [7:0] alt_pin_en;       // alternate function owns pin, lcd off
  logic [7:0] dir_eff;          // direction after forcing
  logic [7:0] read_view;        // what a data read returns
  logic [7:0] rise_det;         // rising edges seen
  logic [7:0] fall_det;         // falling edges seen
  logic [7:0] edge_hit;         // selected, enabled edges

  assign pull_select_eff = PULL_SEL_FIXED ? PULL_SEL_VALUE : pull_select_q;  // RULE7
  assign irq_enable_eff = IRQ_CAPABLE ? irq_enable_q : PPA_RST_VAL;  // RULE8

  // alternate owners per pin, lcd segment wins over all of them
  always_comb begin
    alt_pin_en = '0;
    alt_pin_en[PPA_PIN_IRQ] = alt_en_q[PPA_ALT_IRQ_BIT] && !lcd_seg_en_q[PPA_PIN_IRQ];  // RULE16
    alt_pin_en[PPA_PIN_NMI] = alt_en_q[PPA_ALT_NMI_BIT] && !lcd_seg_en_q[PPA_PIN_NMI];  // RULE15
    alt_pin_en[PPA_PIN_CLK] = alt_en_q[PPA_ALT_CLK_BIT] && !lcd_seg_en_q[PPA_PIN_CLK];  // RULE14
  end

  // forced direction: clock pin output, interrupt pins input
  always_comb begin
    dir_eff = port_a_direction_q;
    if (alt_pin_en[PPA_PIN_CLK]) begin
      dir_eff[PPA_PIN_CLK] = 1'b1;  // RULE18
    end
    if (alt_pin_en[PPA_PIN_NMI]) begin
      dir_eff[PPA_PIN_NMI] = 1'b0;  // RULE18
    end
    if (alt_pin_en[PPA_PIN_IRQ]) begin
      dir_eff[PPA_PIN_IRQ] = 1'b0;  // RULE18
    end
  end

  // per-bit read source and edge detection
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      assign read_view[g] = dir_eff[g] ? port_a_data_q[g] : sync2_q[g];  // RULE12 RULE19
      assign rise_det[g] = sync2_q[g] && !prev_q[g];  // RULE20
      assign fall_det[g] = !sync2_q[g] && prev_q[g];  // RULE20
      // select 0 falling, select 1 rising, direction ignored
      assign edge_hit[g] = irq_enable_eff[g] && (pull_select_eff[g] ? rise_det[g] : fall_det[g]);  // RULE4 RULE6
    end
  endgenerate

  // ****************************************************************
  // register writes
  // ****************************************************************
  // data register, writable any time
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      port_a_data_q <= PPA_RST_VAL;  // RULE10
    end else if (wr_hit(bus_req, PPA_OFS_DATA)) begin
      port_a_data_q <= bus_req.wdata;  // RULE17
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      port_a_direction_q <= PPA_RST_VAL;
      reduced_drive_q <= PPA_RST_VAL;
      pull_enable_q <= PPA_RST_VAL;
      pull_select_q <= PPA_RST_VAL;
      irq_enable_q <= PPA_RST_VAL;
      lcd_seg_en_q <= PPA_RST_VAL;
      alt_en_q <= PPA_RST_VAL;
    end else begin
      if (wr_hit(bus_req, PPA_OFS_DIR)) begin
        port_a_direction_q <= bus_req.wdata;
      end
      if (wr_hit(bus_req, PPA_OFS_WEAK)) begin
        reduced_drive_q <= bus_req.wdata;
      end
      if (wr_hit(bus_req, PPA_OFS_PULL_EN)) begin
        pull_enable_q <= bus_req.wdata;
      end
      if (wr_hit(bus_req, PPA_OFS_PULL_SEL) && !PULL_SEL_FIXED) begin
        pull_select_q <= bus_req.wdata;  // RULE7
      end
      if (wr_hit(bus_req, PPA_OFS_IRQ_EN) && IRQ_CAPABLE) begin
        irq_enable_q <= bus_req.wdata;  // RULE8
      end
      if (wr_hit(bus_req, PPA_OFS_LCD)) begin
        lcd_seg_en_q <= bus_req.wdata;
      end
      if (wr_hit(bus_req, PPA_OFS_ALT)) begin
        alt_en_q <= bus_req.wdata;
      end
    end
  end

  // ****************************************************************
  // pin sampling and edge flags
  // ****************************************************************
  // two-stage synchroniser, then a history stage
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sync1_q <= PPA_RST_VAL;
      sync2_q <= PPA_RST_VAL;
      prev_q <= PPA_RST_VAL;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;  // RULE20
      prev_q <= sync2_q;
    end
  end

  // sticky flags: a new edge beats a write-one clear
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      edge_flags_q <= PPA_RST_VAL;
    end else if (wr_hit(bus_req, PPA_OFS_IF)) begin
      edge_flags_q <= (edge_flags_q & ~bus_req.wdata) | edge_hit;  // RULE20
    end else begin
      edge_flags_q <= edge_flags_q | edge_hit;  // RULE6
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // registered answer, one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rd_data_q <= PPA_READ_IDLE;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        PPA_OFS_DATA: rd_data_q <= read_view;  // RULE9 RULE12 RULE17
        PPA_OFS_DIR: rd_data_q <= port_a_direction_q;
        PPA_OFS_WEAK: rd_data_q <= reduced_drive_q;
        PPA_OFS_PULL_EN: rd_data_q <= pull_enable_q;
        PPA_OFS_PULL_SEL: rd_data_q <= pull_select_eff;
        PPA_OFS_IRQ_EN: rd_data_q <= irq_enable_eff;
        PPA_OFS_IF: rd_data_q <= edge_flags_q;
        PPA_OFS_LCD: rd_data_q <= lcd_seg_en_q;
        PPA_OFS_ALT: rd_data_q <= alt_en_q;
        default: rd_data_q <= PPA_READ_IDLE;  // unmapped offset
      endcase
    end else begin
      rd_data_q <= PPA_READ_IDLE;
    end
  end

  // ****************************************************************
  // pad drive
  // ****************************************************************
  // per-pin priority: lcd, then alternate, then gpio
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pad_out_q <= PPA_RST_VAL;
      pad_oe_q <= PPA_RST_VAL;
      pad_up_q <= PPA_RST_VAL;
      pad_down_q <= PPA_RST_VAL;
      pad_red_q <= PPA_RST_VAL;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (lcd_seg_en_q[i]) begin
          // segment driver owns the pad
          pad_out_q[i] <= lcd_seg_drive[i];  // RULE13
          pad_oe_q[i] <= 1'b1;
          pad_up_q[i] <= 1'b0;
          pad_down_q[i] <= 1'b0;
          pad_red_q[i] <= 1'b0;
        end else begin
          // gpio or clock output, direction already forced
          pad_out_q[i] <= (i == PPA_PIN_CLK && alt_pin_en[i]) ? autonomous_clock_src
                                                             : port_a_data_q[i];  // RULE11 RULE14
          pad_oe_q[i] <= dir_eff[i];  // RULE1
          pad_up_q[i] <= !dir_eff[i] && pull_enable_q[i] && !pull_select_eff[i];  // RULE2 RULE3
          pad_down_q[i] <= !dir_eff[i] && pull_enable_q[i] && pull_select_eff[i];  // RULE2 RULE3
          pad_red_q[i] <= dir_eff[i] && reduced_drive_q[i];  // RULE5
        end
      end
    end
  end

  // interrupt input routes, idle high when not selected
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      nmi_n_q <= 1'b1;
      irq_n_q <= 1'b1;
    end else begin
      nmi_n_q <= alt_pin_en[PPA_PIN_NMI] ? sync2_q[PPA_PIN_NMI] : 1'b1;  // RULE15
      irq_n_q <= alt_pin_en[PPA_PIN_IRQ] ? sync2_q[PPA_PIN_IRQ] : 1'b1;  // RULE16
    end
  end

  // output hookup
  assign rd_data = rd_data_q;
  assign pad_ctl.out = pad_out_q;
  assign pad_ctl.oe = pad_oe_q;
  assign pad_ctl.pull_up = pad_up_q;
  assign pad_ctl.pull_down = pad_down_q;
  assign pad_ctl.reduced = pad_red_q;
  assign nonmaskable_int_input_n = nmi_n_q;
  assign maskable_int_input_n = irq_n_q;
  assign pin_edge_flags = edge_flags_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // an enabled edge is seen, then latched
  sequence s_edge_seen;
    edge_hit != 8'h00;
  endsequence
  sequence s_edge_latched;
    ##1 ((edge_flags_q & $past(edge_hit)) == $past(edge_hit));
  endsequence

  data_reset_a: assert property ($rose(reset_n) |-> port_a_data_q == PPA_RST_VAL)  // RULE10
    else $error("data register not clear after reset");
  read_source_a: assert property (bus_req.rd && bus_req.addr == PPA_OFS_DATA |=>  // RULE12
    rd_data == $past(read_view) && (($past(dir_eff) & (rd_data ^ $past(port_a_data_q))) == 8'h00))
    else $error("data read took the wrong source");
  pull_output_a: assert property ((pad_ctl.oe & ~lcd_seg_en_q & (pad_ctl.pull_up | pad_ctl.pull_down)) == 8'h00)  // RULE3
    else $error("pull device on an output pin");
  pull_dir_a: assert property (##1 ((pad_ctl.pull_up & $past(pull_select_eff)) == 8'h00)
    && ((pad_ctl.pull_down & ~$past(pull_select_eff)) == 8'h00))  // RULE2
    else $error("pull direction disagrees with pull select");
  drive_red_a: assert property ((pad_ctl.reduced & ~pad_ctl.oe) == 8'h00)  // RULE5
    else $error("reduced drive on a non-driven pin");
  edge_latch_a: assert property (s_edge_seen |-> s_edge_latched)  // RULE4
    else $error("enabled edge not flagged");
  irq_block_a: assert property (##1 ((edge_flags_q & ~$past(edge_flags_q) & ~$past(irq_enable_eff)) == 8'h00))  // RULE6
    else $error("flag set with interrupt enable off");
  lcd_prio_a: assert property (lcd_seg_en_q != 8'h00 |=>  // RULE13
    ((pad_ctl.out ^ $past(lcd_seg_drive)) & $past(lcd_seg_en_q)) == 8'h00)
    else $error("lcd segment did not own its pin");
  clk_out_a: assert property (alt_pin_en[PPA_PIN_CLK] |=>  // RULE14
    pad_ctl.oe[PPA_PIN_CLK] && pad_ctl.out[PPA_PIN_CLK] == $past(autonomous_clock_src))
    else $error("clock output not on pin 3");
  nmi_route_a: assert property (alt_pin_en[PPA_PIN_NMI] |=>  // RULE15
    !pad_ctl.oe[PPA_PIN_NMI] && nonmaskable_int_input_n == $past(sync2_q[PPA_PIN_NMI]))
    else $error("nonmaskable input not routed");
  irq_route_a: assert property (alt_pin_en[PPA_PIN_IRQ] |=>  // RULE16
    !pad_ctl.oe[PPA_PIN_IRQ] && maskable_int_input_n == $past(sync2_q[PPA_PIN_IRQ]))
    else $error("maskable input not routed");
  fixed_pull_a: assert property (PULL_SEL_FIXED |-> pull_select_eff == PULL_SEL_VALUE)  // RULE7
    else $error("pull select not held for fixed port");
  no_irq_a: assert property (!IRQ_CAPABLE |-> edge_flags_q == 8'h00)  // RULE8
    else $error("edge flag on port without interrupts");
  dir_settle_a: assert property (wr_hit(bus_req, PPA_OFS_DIR) ##[1:2] bus_req.rd && bus_req.addr == PPA_OFS_DATA
    |=> rd_data == $past(read_view))  // RULE19
    else $error("data read after direction change is stale");

endmodule : ppa_top

//--- ppa_board_model.sv
// behavioural board wired to the eight port a pins
// assumes the pad controls of ppa_top and a single bus clock
`timescale 1ns/1ps
module ppa_board_model (
  input wire logic ref_clk,                  // bus clock
  input wire ppa_pkg::ppa_pad_ctl_t pad_ctl,  // pad controls from the block
  input wire logic [7:0] ext_drive,          // pins the board drives itself
  input wire logic [7:0] ext_level,          // level the board drives
  output logic [7:0] pin_in                  // resolved pin levels
);
  import ppa_pkg::*;
  logic flip_q = 1'b0;  // open pins change level every cycle

  // ****************************************************************
  // floating pattern
  // ****************************************************************
  // an open pin never keeps a stale level the simulator could settle
  always_ff @(posedge ref_clk) begin
    flip_q <= ~flip_q;
  end

  // ****************************************************************
  // pin resolution
  // ****************************************************************
  // block drive first, then board, then pull device, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_ctl.oe[i]) begin
        pin_in[i] = pad_ctl.out[i];
      end else if (ext_drive[i]) begin
        pin_in[i] = ext_level[i];
      end else if (pad_ctl.pull_up[i]) begin
        pin_in[i] = 1'b1;
      end else if (pad_ctl.pull_down[i]) begin
        pin_in[i] = 1'b0;
      end else begin
        pin_in[i] = flip_q ^ i[0];
      end
    end
  end
endmodule : ppa_board_model

//--- tb_ppa_top.sv
// self-checking bench for the port pin configuration block
// assumes ppa_pkg and ppa_top as declared, board model beside it
`timescale 1ns/1ps
module tb_ppa_top;
  import ppa_pkg::*;
  logic ref_clk = 1'b0;  // 20 mhz bus clock
  logic reset_n = 1'b0;  // synchronous reset, active low
  ppa_bus_req_t bus_req = '0;  // register request
  logic [7:0] rd_data;  // read answer
  logic [7:0] pin_in;  // resolved pins
  ppa_pad_ctl_t pad_ctl;  // pad controls
  logic [7:0] lcd_seg_drive = 8'h00;  // segment levels
  logic autonomous_clock_src = 1'b0;  // clock for pin 3
  logic nonmaskable_int_input_n;  // pin 1 route
  logic maskable_int_input_n;  // pin 0 route
  logic [7:0] pin_edge_flags;  // sticky flags
  logic [7:0] ext_drive = 8'hff;  // board drives all pins
  logic [7:0] ext_level = 8'h00;  // board levels
  int mismatches = 0;  // failed compares
  int n_compared = 0;  // compares made
  int cycles = 0;  // timeout counter
  logic [7:0] rv;  // read value
  logic [7:0] ab_rd_data;  // read answer of the fixed-pull port
  logic [7:0] ab_flags;  // flags of the fixed-pull port

  // ****************************************************************
  // clock, design and board
  // ****************************************************************
  always #25 ref_clk = ~ref_clk;
  ppa_top #(.PORT_KIND(PPA_PORT_IRQ)) ppa_top_inst (.ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req),
    .rd_data(rd_data), .pin_in(pin_in), .pad_ctl(pad_ctl), .lcd_seg_drive(lcd_seg_drive),
    .autonomous_clock_src(autonomous_clock_src), .nonmaskable_int_input_n(nonmaskable_int_input_n),
    .maskable_int_input_n(maskable_int_input_n), .pin_edge_flags(pin_edge_flags));
  ppa_board_model ppa_board_model_inst (.ref_clk(ref_clk), .pad_ctl(pad_ctl), .ext_drive(ext_drive),
    .ext_level(ext_level), .pin_in(pin_in));
  // second port of the a/b family on the same bus, fixed pull select and no pin interrupts
  ppa_top ppa_top_ab_inst (.ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req), .rd_data(ab_rd_data),
    .pin_in(pin_in), .pad_ctl(), .lcd_seg_drive(lcd_seg_drive), .autonomous_clock_src(autonomous_clock_src),
    .nonmaskable_int_input_n(), .maskable_int_input_n(), .pin_edge_flags(ab_flags));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // compare with case equality so unknowns never match
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    #1;
    d = rd_data;
  endtask : rd

  // let registered pads and synchronisers land
  task automatic settle();
    repeat (5) @(posedge ref_clk);
    #1;
  endtask : settle

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // reset values and an unmapped read
  task automatic t_reset();
    rd(PPA_OFS_DATA, rv);
    chk(rv, 8'h00, "data after reset");
    chk(pad_ctl.oe, 8'h00, "oe after reset");
    rd(8'h20, rv);
    chk(rv, PPA_READ_IDLE, "unmapped read");
    $display("test reset done");
  endtask : t_reset

  // mixed direction: output pins drive data, input pins read back
  task automatic t_gpio();
    ext_level <= 8'ha0;
    ext_drive <= 8'hf0;
    wr(PPA_OFS_DATA, 8'h5a);
    wr(PPA_OFS_WEAK, 8'hff);
    wr(PPA_OFS_DIR, 8'h0f);
    rd(PPA_OFS_DATA, rv);
    chk(rv, 8'haa, "read right after dir change");
    settle();
    chk(pad_ctl.oe, 8'h0f, "oe follows direction");
    chk(pad_ctl.out & 8'h0f, 8'h0a, "out follows data");
    chk(pad_ctl.reduced, 8'h0f, "reduced on outputs only");
    rd(PPA_OFS_DATA, rv);
    chk(rv, 8'haa, "register or pin per direction");
    $display("test gpio done");
  endtask : t_gpio

  // pull devices on inputs only, direction by select
  task automatic t_pull();
    wr(PPA_OFS_PULL_EN, 8'hff);
    wr(PPA_OFS_PULL_SEL, 8'h33);
    rd(PPA_OFS_PULL_SEL, rv);
    chk(rv, 8'h33, "pull select writable on irq port");
    chk(ab_rd_data, PPA_ALL_ONES, "pull select fixed on a/b port");
    settle();
    chk(pad_ctl.pull_up, 8'hc0, "pull up where select 0");
    chk(pad_ctl.pull_down, 8'h30, "pull down where select 1");
    wr(PPA_OFS_PULL_EN, 8'h00);
    settle();
    chk(pad_ctl.pull_up | pad_ctl.pull_down, 8'h00, "no pull when disabled");
    $display("test pull done");
  endtask : t_pull

  // rising on bit 2, falling on bit 4, bit 3 not enabled
  task automatic t_edge();
    ext_drive <= 8'hff;
    ext_level <= 8'h10;
    wr(PPA_OFS_DIR, 8'h00);
    wr(PPA_OFS_PULL_SEL, 8'h04);
    wr(PPA_OFS_IRQ_EN, 8'h14);
    settle();
    wr(PPA_OFS_IF, 8'hff);
    settle();
    chk(pin_edge_flags, 8'h00, "flags cleared");
    ext_level <= 8'h0c;
    settle();
    chk(pin_edge_flags, 8'h14, "edge per select, none without enable");
    chk(ab_flags, 8'h00, "no flags on a/b port");
    wr(PPA_OFS_IF, 8'h04);
    settle();
    chk(pin_edge_flags, 8'h10, "write one clears");
    ext_level <= 8'h10;
    settle();
    chk(pin_edge_flags, 8'h10, "wrong edges ignored");
    wr(PPA_OFS_IRQ_EN, 8'h00);
    $display("test edge done");
  endtask : t_edge

  // alternates beat gpio, lcd beats the clock output and the nmi route
  task automatic t_alt();
    ext_level <= 8'h01;
    wr(PPA_OFS_DIR, 8'hff);
    wr(PPA_OFS_DATA, 8'h00);
    autonomous_clock_src <= 1'b1;
    wr(PPA_OFS_ALT, 8'h0b);
    settle();
    chk(pad_ctl.oe, 8'hfc, "nmi and irq pins forced input");
    chk({6'h00, nonmaskable_int_input_n, maskable_int_input_n}, 8'h01, "pins routed");
    chk(pad_ctl.out & 8'h08, 8'h08, "clock out on pin 3");
    wr(PPA_OFS_DIR, 8'h00);
    settle();
    chk(pad_ctl.oe & 8'h08, 8'h08, "clock forces output");
    lcd_seg_drive <= 8'h02;
    wr(PPA_OFS_LCD, 8'h0a);
    settle();
    chk(pad_ctl.oe & 8'h0a, 8'h0a, "lcd drives pins");
    chk(pad_ctl.out & 8'h0a, 8'h02, "lcd level beats clock");
    chk({7'h00, nonmaskable_int_input_n}, 8'h01, "nmi released under lcd");
    $display("test alt done");
  endtask : t_alt

  // ****************************************************************
  // run control
  // ****************************************************************
  // counts, verdict and end of run
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // hang guard, far above the roughly 110 cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end

  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_gpio();
    t_pull();
    t_edge();
    t_alt();
    conclude();
  end
endmodule : tb_ppa_top
